// File: design/rc8_core.sv
// 8-bit core datapath: two-stage fetch/execute, ALU, status, banked data memory
`timescale 1ns/100ps
module rc8_core
  import rc8_pkg::*;
#(
  parameter int ADDR_W      = 9,
  parameter int STACK_DEPTH = 8,
  parameter bit BANK1_RAM   = 1'b0
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [IW-1:0]     prog_data,
  output      logic [ADDR_W-1:0] prog_addr_q,
  input  wire logic [DW-1:0]     sfr_rdata,
  output      logic [7:0]        sfr_addr_q,
  output      logic [DW-1:0]     sfr_wdata_q,
  output      logic              sfr_we_q,
  output      logic [DW-1:0]     accum_q,
  output      logic [DW-1:0]     status_q
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [IW-1:0]     ir_q;
  logic              valid_q;
  logic [ADDR_W-1:0] exec_pc_q;
  logic [7:0]        fsr_q;
  logic [7:0]        program_counter_high_latch_q;
  logic [SP_W-1:0]   sp_q;
  logic [ADDR_W-1:0] stack_q [STACK_DEPTH];
  logic [7:0]        gpr_q [GPR_WORDS];
  logic [7:0]        alu_res;

  // Instruction fields
  wire [1:0] cls   = ir_q[13:12];
  wire [3:0] op    = ir_q[11:8];
  wire [1:0] bop   = ir_q[11:10];
  wire [2:0] bitn  = ir_q[9:7];
  wire [6:0] fadr  = ir_q[6:0];
  wire [7:0] lit   = ir_q[7:0];
  wire       to_f  = ir_q[7];
  wire       ex_by = valid_q && cls == CL_BYTE;
  wire       ex_bt = valid_q && cls == CL_BIT;
  wire       ex_lt = valid_q && cls == CL_LIT;

  // Address resolution
  wire [7:0] dir_adr = {status_q[ST_BANK], fadr};
  wire [7:0] eff_adr = (fadr == A_INDIRECT[6:0]) ? fsr_q : dir_adr;
  wire       mirror  = eff_adr[7] && (eff_adr inside {A_INDIRECT_B1, A_PCL_B1, A_STATUS_B1,
                       A_FSR_B1, A_PROGRAM_COUNTER_HIGH_LATCH_B1, A_INTCTL_B1});
  wire [7:0] can_adr = mirror ? {1'b0, eff_adr[6:0]} : eff_adr;
  wire       hit_g0  = can_adr >= A_GPR0_LO && can_adr <= A_GPR0_HI;
  wire       hit_g1  = BANK1_RAM && can_adr >= A_GPR1_LO && can_adr <= A_GPR1_HI;
  wire       hit_per = can_adr inside {A_TIMER, A_PORT_A_PINS_PINS, A_PORT_B_PINS_PINS, A_INTCTL,
                       A_PERIF_FLAGS, A_CMP_CTL, A_OPTION, A_PORT_A_PINS_DIR, A_PORT_B_PINS_DIR,
                       A_PERIF_ENA, A_PWR_CTL, A_VREF_CTL};
  wire [7:0] g1_off  = can_adr - A_GPR1_LO + 8'(GPR0_WORDS);
  wire [7:0] g0_off  = can_adr - A_GPR0_LO;
  wire [6:0] gpr_idx = hit_g1 ? g1_off[6:0] : g0_off[6:0];
  wire [7:0] pcl_rd  = exec_pc_q[7:0];

  // Read mux; anything unmapped, or indirect through pointer zero, reads zero
  wire [7:0] file_rd =
    (hit_g0 || hit_g1)   ? gpr_q[gpr_idx] :
    (can_adr == A_PCL)    ? pcl_rd :
    (can_adr == A_STATUS) ? status_q :
    (can_adr == A_FSR)    ? fsr_q :
    (can_adr == A_PROGRAM_COUNTER_HIGH_LATCH) ? program_counter_high_latch_q :
    hit_per               ? sfr_rdata : 8'h00;

  // ALU operands and adders
  wire [7:0] opb     = (cls == CL_LIT) ? lit : file_rd;
  wire       sub_sel = op == OP_SUB;
  wire [7:0] addend  = sub_sel ? ~accum_q : accum_q;
  // Subtract as b + ~w + 1, so carry outs come out as inverted borrows
  wire [4:0] nib_sum = {1'b0, opb[3:0]} + {1'b0, addend[3:0]} + 5'(sub_sel);
  wire [8:0] sum     = {1'b0, opb} + {1'b0, addend} + 9'(sub_sel);
  wire       c_in    = status_q[ST_C];
  wire [7:0] bmask   = 8'h01 << bitn;

  always_comb
  begin
    case (op)
      OP_MOVWF: alu_res = accum_q;
      OP_CLR:   alu_res = 8'h00;
      OP_SUB:   alu_res = sum[7:0];
      OP_ADD:   alu_res = sum[7:0];
      OP_DEC:   alu_res = opb - 8'h01;
      OP_DECSZ: alu_res = opb - 8'h01;
      OP_INC:   alu_res = opb + 8'h01;
      OP_INCSZ: alu_res = opb + 8'h01;
      OP_IOR:   alu_res = accum_q | opb;
      OP_AND:   alu_res = accum_q & opb;
      OP_XOR:   alu_res = accum_q ^ opb;
      OP_COM:   alu_res = ~opb;
      OP_RRF:   alu_res = {c_in, opb[7:1]};
      OP_RLF:   alu_res = {opb[6:0], c_in};
      OP_SWAP:  alu_res = {opb[3:0], opb[7:4]};
      default:  alu_res = opb;
    endcase
  end

  // Which flags this instruction drives
  wire z_upd  = (ex_by && (op inside {OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR,
                OP_ADD, OP_MOV, OP_COM, OP_INC})) ||
                (ex_lt && (op inside {OP_SUB, OP_IOR, OP_AND, OP_XOR, OP_ADD}));
  wire cd_upd = (ex_by || ex_lt) && (op == OP_SUB || op == OP_ADD);
  wire c_upd  = ex_by && (op == OP_RRF || op == OP_RLF);
  wire rot_c  = (op == OP_RRF) ? opb[0] : opb[7];
  wire [7:0] flag_msk = {5'h00, z_upd, cd_upd, cd_upd | c_upd};
  wire [7:0] flag_val = {5'h00, alu_res == 8'h00, nib_sum[4], c_upd ? rot_c : sum[8]};

  // Destinations
  wire [7:0] bit_res = bop[0] ? (file_rd | bmask) : (file_rd & ~bmask);
  wire [7:0] wr_data = (cls == CL_BIT) ? bit_res : alu_res;
  wire       file_wr = (ex_by && to_f) || (ex_bt && !bop[1]);
  wire       ret     = ex_lt && (op == LO_RETURN || op == LO_RETLW);
  wire       w_wr    = (ex_by && !to_f) || (ex_lt && op != LO_RETURN && op != LO_NOP);
  wire [7:0] w_data  = (cls == CL_LIT && op == LO_RETLW) ? lit : alu_res;
  wire       gpr_wr  = file_wr && (hit_g0 || hit_g1);
  wire       st_wr   = file_wr && can_adr == A_STATUS;
  wire       pcl_wr  = file_wr && can_adr == A_PCL;

  // Status: any flag-affecting op blocks the data write to all three flags
  wire       flag_any = |flag_msk;
  wire [7:0] st_wmsk = st_wr ? (STATUS_WR_MSK & ~{5'h00, {3{flag_any}}}) : 8'h00;
  wire [7:0] st_mid  = (status_q & ~st_wmsk) | (wr_data & st_wmsk);
  wire [7:0] st_d    = (st_mid & ~flag_msk) | (flag_val & flag_msk);

  // Program flow; a skip simply discards the word already fetched
  wire       bit_set = |(file_rd & bmask);
  wire       skip    = (ex_by && (op == OP_DECSZ || op == OP_INCSZ) && alu_res == 8'h00) ||
                       (ex_bt && bop[1] && (bop[0] == bit_set));
  wire       jump    = valid_q && cls == CL_JUMP;
  wire       call    = jump && ir_q[11];
  wire       flush   = skip || jump || ret || pcl_wr;
  wire [SP_W-1:0] sp_prev  = sp_q - 1'b1;
  wire [12:0]     jmp_full = {program_counter_high_latch_q[4:3], ir_q[10:0]};
  wire [12:0]     pcl_full = {program_counter_high_latch_q[4:0], wr_data};
  // Upper address bits beyond ADDR_W are dropped: no external program space
  wire [ADDR_W-1:0] pc_d =
    jump   ? jmp_full[ADDR_W-1:0] :
    pcl_wr ? pcl_full[ADDR_W-1:0] :
    ret    ? stack_q[sp_prev] : prog_addr_q + 1'b1;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prog_addr_q <= '0;
      exec_pc_q   <= '0;
      ir_q        <= '0;
      valid_q     <= 1'b0;
      accum_q     <= REG_RST;
      status_q    <= STATUS_RST;
      fsr_q       <= REG_RST;
      program_counter_high_latch_q    <= REG_RST;
      sp_q        <= '0;
      sfr_addr_q  <= REG_RST;
      sfr_wdata_q <= REG_RST;
      sfr_we_q    <= 1'b0;
    end
    else
    begin
      prog_addr_q <= pc_d;
      exec_pc_q   <= prog_addr_q;
      ir_q        <= prog_data;
      valid_q     <= !flush;
      status_q    <= st_d;
      if (w_wr)
        accum_q <= w_data;
      if (file_wr && can_adr == A_FSR)
        fsr_q <= wr_data;
      if (file_wr && can_adr == A_PROGRAM_COUNTER_HIGH_LATCH)
        program_counter_high_latch_q <= wr_data;
      if (call)
        sp_q <= sp_q + 1'b1;
      else if (ret)
        sp_q <= sp_prev;
      // Peripheral registers sit outside on their own data bus
      sfr_we_q    <= file_wr && hit_per;
      sfr_addr_q  <= can_adr;
      sfr_wdata_q <= wr_data;
    end
  end

  // Storage arrays carry no reset; contents are undefined after power-up
  always_ff @(posedge clk)
  begin
    if (gpr_wr)
      gpr_q[gpr_idx] <= wr_data;
    if (call)
      stack_q[sp_q] <= prog_addr_q;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  a_fetch_word: assert property (!flush |=> valid_q && ir_q == $past(prog_data))
    else $error("fetched word not taken into execute");
  a_pc_advance: assert property (!flush |=> prog_addr_q == $past(prog_addr_q) + 1'b1)
    else $error("program counter did not advance");
  a_branch_gap: assert property (flush |=> !valid_q ##1 valid_q)
    else $error("branch did not cost exactly one bubble");
  a_lit_add: assert property (ex_lt && op == OP_ADD |=> accum_q == $past(accum_q + lit))
    else $error("literal add result wrong");
  a_sub_borrow: assert property (ex_lt && op == OP_SUB
    |=> status_q[ST_C] == ($past(lit) >= $past(accum_q)))
    else $error("subtract carry is not inverted borrow");
  a_zero_flag: assert property (z_upd |=> status_q[ST_Z] == ($past(alu_res) == 8'h00))
    else $error("zero flag mismatch");
  a_status_clr: assert property (st_wr && ex_by && op == OP_CLR
    |=> status_q[ST_Z] && status_q[7:5] == 3'h0 && status_q[ST_TO]
        && status_q[1:0] == $past(status_q[1:0]))
    else $error("clear of status not masked by flag logic");
  a_tmo_pd_hold: assert property (status_q[ST_TO] && status_q[ST_PD])
    else $error("time-out or power-down flag changed");
  a_indirect_wr: assert property (ex_by && to_f && fadr == 7'h00 && fsr_q == A_PROGRAM_COUNTER_HIGH_LATCH
    |=> program_counter_high_latch_q == $past(alu_res))
    else $error("indirect write missed pointer target");
  a_bank_mirror: assert property (file_wr && dir_adr == A_FSR_B1 |=> fsr_q == $past(wr_data))
    else $error("bank 1 pointer alias failed");
  a_unimpl_zero: assert property (valid_q && can_adr == A_INDIRECT |-> file_rd == 8'h00)
    else $error("unimplemented location read non-zero");
  a_sfr_write: assert property (file_wr && hit_per
    |=> sfr_we_q && sfr_addr_q == $past(can_adr) ##1 !sfr_we_q || $past(file_wr && hit_per))
    else $error("peripheral write strobe wrong");

  a_acc_hold: assert property (!w_wr |=> accum_q == $past(accum_q))
    else $error("accumulator changed without a write");

  a_acc_write: assert property (w_wr |=> accum_q == $past(w_data))
    else $error("accumulator write lost");

  a_upper_zero: assert property (status_q[7:6] == 2'h0)
    else $error("unused status bits not zero");

  a_bank_set: assert property (ex_bt && !bop[1] && can_adr == A_STATUS && bitn == 3'(ST_BANK)
    |=> status_q[ST_BANK] == $past(bop[0]))
    else $error("bank select bit not updated");

  a_lit_and: assert property (ex_lt && op == OP_AND |=> accum_q == $past(accum_q & lit))
    else $error("literal and result wrong");

  a_lit_ior: assert property (ex_lt && op == OP_IOR |=> accum_q == $past(accum_q | lit))
    else $error("literal or result wrong");

  a_lit_xor: assert property (ex_lt && op == OP_XOR |=> accum_q == $past(accum_q ^ lit))
    else $error("literal xor result wrong");

  a_lit_sub: assert property (ex_lt && op == OP_SUB |=> accum_q == $past(lit - accum_q))
    else $error("literal subtract result wrong");

  a_add_carry: assert property (ex_lt && op == OP_ADD
    |=> status_q[ST_C] == ($past({1'b0, lit} + {1'b0, accum_q}) > 9'h0FF))
    else $error("add carry wrong");

  a_add_dcarry: assert property (ex_lt && op == OP_ADD
    |=> status_q[ST_DC] == ($past({1'b0, lit[3:0]} + {1'b0, accum_q[3:0]}) > 5'h0F))
    else $error("add digit carry wrong");

  a_sub_dborrow: assert property (ex_lt && op == OP_SUB
    |=> status_q[ST_DC] == ($past(lit[3:0]) >= $past(accum_q[3:0])))
    else $error("subtract digit carry is not inverted borrow");

  a_rlf_shift: assert property (ex_by && op == OP_RLF && !to_f
    |=> accum_q == {$past(opb[6:0]), $past(c_in)} && status_q[ST_C] == $past(opb[7]))
    else $error("rotate left wrong");

  a_rrf_shift: assert property (ex_by && op == OP_RRF && !to_f
    |=> accum_q == {$past(c_in), $past(opb[7:1])} && status_q[ST_C] == $past(opb[0]))
    else $error("rotate right wrong");

  a_pcl_read: assert property (valid_q && can_adr == A_PCL |-> file_rd == exec_pc_q[7:0])
    else $error("program counter low read wrong");

  a_jump_target: assert property (jump |=> prog_addr_q == $past(jmp_full[ADDR_W-1:0]))
    else $error("jump target wrong");

  a_call_push: assert property (call |=> sp_q == $past(sp_q) + 1'b1)
    else $error("call did not push");

  a_ret_pop: assert property (ret |=> sp_q == $past(sp_prev))
    else $error("return did not pop");

  a_skip_bubble: assert property (skip |=> !valid_q)
    else $error("skipped word not discarded");

  a_we_source: assert property (sfr_we_q |-> $past(file_wr && hit_per))
    else $error("peripheral strobe without a write");

  a_no_we_int: assert property (file_wr && !hit_per |=> !sfr_we_q)
    else $error("internal write leaked to peripheral bus");

  a_fsr_write: assert property (file_wr && can_adr == A_FSR |=> fsr_q == $past(wr_data))
    else $error("pointer write lost");

  a_bit_clear: assert property (ex_bt && bop == BO_CLR && can_adr == A_FSR
    |=> fsr_q == ($past(fsr_q) & ~$past(bmask)))
    else $error("bit clear on pointer wrong");

  a_status_bank: assert property (st_wr && flag_msk == 8'h00
    |=> status_q[ST_BANK] == $past(wr_data[ST_BANK]))
    else $error("status data write lost");

  a_bank_zero: assert property (!status_q[ST_BANK] && valid_q && fadr != 7'h00
    |-> !eff_adr[7])
    else $error("bank 0 direct address wrong");

  a_bank_one: assert property (status_q[ST_BANK] && valid_q && fadr != 7'h00
    |-> eff_adr[7])
    else $error("bank 1 direct address wrong");

  a_mirror_fold: assert property (mirror |-> !can_adr[7])
    else $error("shared register not folded to bank 0");

  a_indirect_adr: assert property (valid_q && fadr == 7'h00 |-> eff_adr == fsr_q)
    else $error("indirect address not from pointer");

endmodule // rc8_core

// File: design/rc8_pkg.sv
// Constants for the 8-bit core datapath, its data memory map and instruction fields
package rc8_pkg;
  // Data memory map, full addresses {bank, offset}
  localparam logic [7:0] A_INDIRECT    = 8'h00;
  localparam logic [7:0] A_TIMER       = 8'h01;
  localparam logic [7:0] A_PCL         = 8'h02;
  localparam logic [7:0] A_STATUS      = 8'h03;
  localparam logic [7:0] A_FSR         = 8'h04;
  localparam logic [7:0] A_PORT_A_PINS_PINS  = 8'h05;
  localparam logic [7:0] A_PORT_B_PINS_PINS  = 8'h06;
  localparam logic [7:0] A_PROGRAM_COUNTER_HIGH_LATCH      = 8'h0A;
  localparam logic [7:0] A_INTCTL      = 8'h0B;
  localparam logic [7:0] A_PERIF_FLAGS = 8'h0C;
  localparam logic [7:0] A_CMP_CTL     = 8'h1F;
  localparam logic [7:0] A_INDIRECT_B1 = 8'h80;
  localparam logic [7:0] A_OPTION      = 8'h81;
  localparam logic [7:0] A_PCL_B1      = 8'h82;
  localparam logic [7:0] A_STATUS_B1   = 8'h83;
  localparam logic [7:0] A_FSR_B1      = 8'h84;
  localparam logic [7:0] A_PORT_A_PINS_DIR   = 8'h85;
  localparam logic [7:0] A_PORT_B_PINS_DIR   = 8'h86;
  localparam logic [7:0] A_PROGRAM_COUNTER_HIGH_LATCH_B1   = 8'h8A;
  localparam logic [7:0] A_INTCTL_B1   = 8'h8B;
  localparam logic [7:0] A_PERIF_ENA   = 8'h8C;
  localparam logic [7:0] A_PWR_CTL     = 8'h8E;
  localparam logic [7:0] A_VREF_CTL    = 8'h9F;
  localparam logic [7:0] A_GPR0_LO     = 8'h20;
  localparam logic [7:0] A_GPR0_HI     = 8'h7F;
  localparam logic [7:0] A_GPR1_LO     = 8'hA0;
  localparam logic [7:0] A_GPR1_HI     = 8'hBF;
  localparam int         GPR0_WORDS    = 96;
  localparam int         GPR_WORDS     = 128;
  // Status fields
  localparam int         ST_C          = 0;
  localparam int         ST_DC         = 1;
  localparam int         ST_Z          = 2;
  localparam int         ST_PD         = 3;
  localparam int         ST_TO         = 4;
  localparam int         ST_BANK       = 5;
  localparam logic [7:0] STATUS_RST    = 8'h18;
  localparam logic [7:0] STATUS_WR_MSK = 8'h27;
  // Widths and reset values
  localparam int         IW            = 14;
  localparam int         DW            = 8;
  localparam logic [7:0] REG_RST       = 8'h00;
  // Instruction classes, ir[13:12]
  localparam logic [1:0] CL_BYTE       = 2'h0;
  localparam logic [1:0] CL_BIT        = 2'h1;
  localparam logic [1:0] CL_JUMP       = 2'h2;
  localparam logic [1:0] CL_LIT        = 2'h3;
  // ALU operations, ir[11:8]; literal class reuses the codes it shares
  localparam logic [3:0] OP_MOVWF      = 4'h0;
  localparam logic [3:0] OP_CLR        = 4'h1;
  localparam logic [3:0] OP_SUB        = 4'h2;
  localparam logic [3:0] OP_DEC        = 4'h3;
  localparam logic [3:0] OP_IOR        = 4'h4;
  localparam logic [3:0] OP_AND        = 4'h5;
  localparam logic [3:0] OP_XOR        = 4'h6;
  localparam logic [3:0] OP_ADD        = 4'h7;
  localparam logic [3:0] OP_MOV        = 4'h8;
  localparam logic [3:0] OP_COM        = 4'h9;
  localparam logic [3:0] OP_INC        = 4'hA;
  localparam logic [3:0] OP_DECSZ      = 4'hB;
  localparam logic [3:0] OP_RRF        = 4'hC;
  localparam logic [3:0] OP_RLF        = 4'hD;
  localparam logic [3:0] OP_SWAP       = 4'hE;
  localparam logic [3:0] OP_INCSZ      = 4'hF;
  localparam logic [3:0] LO_RETURN     = 4'h0;
  localparam logic [3:0] LO_RETLW      = 4'h1;
  localparam logic [3:0] LO_NOP        = 4'h3;
  // Bit operations, ir[11:10]
  localparam logic [1:0] BO_CLR        = 2'h0;
  localparam logic [1:0] BO_SET        = 2'h1;
  localparam logic [1:0] BO_SKIP_CLR   = 2'h2;
  localparam logic [1:0] BO_SKIP_SET   = 2'h3;
endpackage

// File: tb/rc8_mem.sv
// Program memory and peripheral register model on the far side of the core
`timescale 1ns/100ps
module rc8_mem
  import rc8_pkg::*;
(
  input  wire logic          clk,
  input  wire logic [8:0]    addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          wr_en,
  output      logic [IW-1:0] prog_data,
  output      logic [DW-1:0] rd_data
);
  logic [IW-1:0] mem [0:511];
  logic [DW-1:0] last_q;

  initial
  begin
    for (int n = 0; n < 512; n++)
      mem[n] = {CL_LIT, LO_NOP, 8'h00};
    last_q = 8'h00;
    prog_data = 14'h0000;
    rd_data = 8'h00;
  end

  // Whole word handed over each cycle, off the core's sampling edge
  always @(negedge clk)
  begin
    prog_data <= mem[addr];
    rd_data <= (wr_en === 1'b1) ? wr_data : last_q;
  end

  // Reads return the latest peripheral write; a write in flight is forwarded
  always @(posedge clk)
    if (wr_en === 1'b1)
      last_q <= wr_data;
endmodule // rc8_mem

// File: tb/risc8_core_datapath_memmap_test.sv
// Self-checking bench: runs a generated program and checks peripheral writes
`timescale 1ns/100ps
module risc8_core_datapath_memmap_test
  import rc8_pkg::*;
;
  logic          clk;
  logic          rst;
  logic [IW-1:0] prog_data;
  logic [8:0]    prog_addr_q;
  logic [DW-1:0] sfr_rdata;
  logic [7:0]    sfr_addr_q;
  logic [DW-1:0] sfr_wdata_q;
  logic          sfr_we_q;
  logic [DW-1:0] accum_q;
  logic [DW-1:0] status_q;
  logic [24:0]   exp_q[$];
  logic [24:0]   e;
  logic [31:0]   seed = 32'h8A8061AC;
  logic [7:0]    w, last;
  logic          c, dc, z, bank;
  int            pc, i, miscompares, checked;

  rc8_core u_dut (.clk(clk), .rst(rst), .prog_data(prog_data), .prog_addr_q(prog_addr_q),
    .sfr_rdata(sfr_rdata), .sfr_addr_q(sfr_addr_q), .sfr_wdata_q(sfr_wdata_q),
    .sfr_we_q(sfr_we_q), .accum_q(accum_q), .status_q(status_q));
  rc8_mem u_mem (.clk(clk), .addr(prog_addr_q), .wr_data(sfr_wdata_q), .wr_en(sfr_we_q),
    .prog_data(prog_data), .rd_data(sfr_rdata));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] st();
    return {2'b00, bank, 2'b11, z, dc, c};
  endfunction

  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic emit(input logic [13:0] ins);
    u_mem.mem[pc] = ins;
    pc++;
  endtask

  // Store accumulator; the peripheral write shows two fetches later
  task automatic wf(input logic [6:0] f, input logic [7:0] a);
    exp_q.push_back({a, w, 9'(pc + 2)});
    last = w;
    emit({CL_BYTE, OP_MOVWF, 1'b1, f});
  endtask

  task automatic rdst();
    emit({CL_BYTE, OP_MOV, 1'b0, 7'h03});
    w = st();
    z = (w == 8'h00);
  endtask

  task automatic lit(input logic [3:0] op, input logic [7:0] k);
    logic [8:0] r;
    emit({CL_LIT, op, k});
    case (op)
      OP_ADD:
      begin
        r = w + k;
        dc = (w[3:0] + k[3:0]) > 5'h0F;
        c = r[8];
        w = r[7:0];
      end
      OP_SUB:
      begin
        dc = k[3:0] >= w[3:0];
        c = k >= w;
        w = k - w;
      end
      OP_IOR: w = w | k;
      OP_AND: w = w & k;
      OP_XOR: w = w ^ k;
      default: w = k;
    endcase
    if (op != OP_MOV)
      z = (w == 8'h00);
  endtask

  task automatic alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] k);
    lit(OP_MOV, a);
    lit(op, k);
    wf(7'h0C, 8'h0C);
    rdst();
    wf(7'h0C, 8'h0C);
  endtask

  task automatic build();
    {pc, w, c, dc, z, bank} = 0;
    alu(OP_IOR, rnd(), rnd());
    alu(OP_AND, rnd(), rnd());
    alu(OP_XOR, rnd(), rnd());
    alu(OP_ADD, rnd(), rnd());
    alu(OP_SUB, rnd(), rnd());
    alu(OP_ADD, 8'hF8, 8'h08);
    alu(OP_SUB, 8'h10, 8'h10);
    alu(OP_SUB, 8'h01, 8'h00);
    emit({CL_BIT, BO_SET, 3'h5, 7'h03});
    bank = 1'b1;
    wf(7'h05, 8'h85);
    wf(7'h0B, 8'h0B);
    emit({CL_BIT, BO_CLR, 3'h5, 7'h03});
    bank = 1'b0;
    lit(OP_MOV, 8'h0C);
    emit({CL_BYTE, OP_MOVWF, 1'b1, 7'h04});
    lit(OP_MOV, rnd());
    wf(7'h00, 8'h0C);
    emit({CL_BYTE, OP_MOVWF, 1'b1, 7'h07});
    emit({CL_BYTE, OP_MOV, 1'b0, 7'h07});
    {w, z} = 9'h001;
    wf(7'h0C, 8'h0C);
    lit(OP_MOV, 8'h00);
    emit({CL_BYTE, OP_MOVWF, 1'b1, 7'h03});
    {z, dc, c} = 3'h0;
    emit({CL_BYTE, OP_CLR, 1'b1, 7'h03});
    z = 1'b1;
    rdst();
    wf(7'h0C, 8'h0C);
    exp_q.push_back({8'h0C, 8'(last + 1), 9'(pc + 2)});
    emit({CL_BYTE, OP_INC, 1'b1, 7'h0C});
    last = last + 1;
    z = (last == 8'h00);
    emit({CL_BYTE, OP_MOVWF, 1'b1, 7'h20});
    emit({CL_BYTE, OP_RLF, 1'b0, 7'h20});
    {c, w} = {w, c};
    wf(7'h0C, 8'h0C);
    emit({CL_BYTE, OP_MOVWF, 1'b1, 7'h20});
    emit({CL_BYTE, OP_RRF, 1'b0, 7'h20});
    {w, c} = {c, w};
    wf(7'h0C, 8'h0C);
    emit({CL_JUMP, 1'b0, 11'(pc + 2)});
    emit({CL_LIT, OP_MOV, 8'h55});
    wf(7'h0C, 8'h0C);
    emit({CL_JUMP, 1'b0, 11'(pc)});
  endtask

  always @(negedge clk)
  begin
    if (rst === 1'b0 && sfr_we_q === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h0000000;
      check({sfr_addr_q, sfr_wdata_q, prog_addr_q}, e);
    end
  end

  initial
  begin
    rst = 1'b1;
    // Let the memory model clear itself before the program is loaded
    #1;
    build();
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 2000 && exp_q.size() != 0; i++)
      @(negedge clk);
    if (exp_q.size() != 0)
    begin
      miscompares++;
      $display("unexpected at %0t: writes missing", $time);
      end_of_test();
    end
    repeat (4) @(negedge clk);
    check(accum_q, w);
    check(status_q, st());
    $display("test program done");
    rst = 1'b1;
    #10;
    check({prog_addr_q, sfr_we_q}, 10'h000);
    check({accum_q, status_q}, {REG_RST, STATUS_RST});
    $display("test reset done");
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({prog_addr_q, sfr_we_q}, 10'h004);
    $display("test reset release done");
    end_of_test();
  end
endmodule // risc8_core_datapath_memmap_test
